// [src/tds_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tds_top
    import tds_pkg::*;
(
    input wire logic ref_clk, // 100 MHz system clock
    input wire logic nrst, // Async reset, active low
    input wire logic tck, // Test clock pin
    input wire logic tms, // Test mode select pin
    input wire logic tdi, // Test data in pin
    output logic tdo_o, // Test data out value
    output logic tdo_oe, // Test data out enable
    output logic upd_q_o, // Parallel update stage
    output logic tlr_o, // Controller in Test-Logic-Reset
    output logic rec_valid, // Shifted-in bit available
    input wire logic rec_ready, // Consumer takes bit
    output logic rec_data // Shifted-in bit
);
    logic [1:0] tck_s_q, tms_s_q, tdi_s_q;
    logic tck_prev_q;
    logic rise, fall;
    tds_state_t st_q, st_d;
    logic byp_q, byp_d;
    logic tdo_q, tdo_d, oe_q, oe_d, upd_q, upd_d, tlr_q, tlr_d;
    logic val_q, val_d, dat_q, dat_d;
    logic fin_valid, fin_ready, fout_valid, fout_data;

    // Pins cross into ref_clk via two flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tck_s_q <= TDS_SYNC_RST;
            tms_s_q <= TDS_SYNC_RST;
            tdi_s_q <= TDS_SYNC_RST;
            tck_prev_q <= TDS_RST_BIT;
        end else begin
            tck_s_q <= {tck_s_q[0], tck};
            tms_s_q <= {tms_s_q[0], tms};
            tdi_s_q <= {tdi_s_q[0], tdi};
            tck_prev_q <= tck_s_q[1];
        end
    end

    assign rise = tck_s_q[1] && !tck_prev_q;
    assign fall = !tck_s_q[1] && tck_prev_q;

    // Rising edge work: state, capture, shift
    always_comb begin
        st_d = st_q;
        byp_d = byp_q;
        if (rise) begin
            st_d = tds_next(st_q, tms_s_q[1]);
            if (st_q == TDS_CAP_DR) begin
                byp_d = TDS_CAPTURE_VAL;
            end else if (st_q == TDS_SHIFT_DR) begin
                byp_d = tdi_s_q[1];
            end
        end
    end

    // Falling edge work: every pin-level output moves here
    always_comb begin
        tdo_d = tdo_q;
        oe_d = oe_q;
        upd_d = upd_q;
        tlr_d = tlr_q;
        if (fall) begin
            oe_d = (st_q == TDS_SHIFT_DR);
            tdo_d = byp_q;
            tlr_d = (st_q == TDS_TLR);
            if (st_q == TDS_UPD_DR) begin
                upd_d = byp_q;
            end
        end
    end

    // Shifted bits go to the record FIFO; stall holds one bit until the next shifted bit overwrites it
    always_comb begin
        val_d = val_q;
        dat_d = dat_q;
        if (val_q && fin_ready) begin
            val_d = 1'b0;
        end
        if (rise && st_q == TDS_SHIFT_DR) begin
            val_d = 1'b1;
            dat_d = tdi_s_q[1];
        end
    end
    assign fin_valid = val_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= TDS_TLR;
            byp_q <= TDS_RST_BIT;
            tdo_q <= TDS_RST_BIT;
            oe_q <= TDS_RST_BIT;
            upd_q <= TDS_RST_BIT;
            tlr_q <= 1'b1;
            val_q <= TDS_RST_BIT;
            dat_q <= TDS_RST_BIT;
        end else begin
            st_q <= st_d;
            byp_q <= byp_d;
            tdo_q <= tdo_d;
            oe_q <= oe_d;
            upd_q <= upd_d;
            tlr_q <= tlr_d;
            val_q <= val_d;
            dat_q <= dat_d;
        end
    end

    // Output buffer stage so rec_* come from flops
    logic rv_q, rv_d, rd_q, rd_d;
    always_comb begin
        rv_d = rv_q;
        rd_d = rd_q;
        if (!rv_q || rec_ready) begin
            rv_d = fout_valid;
            rd_d = fout_data;
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rv_q <= TDS_RST_BIT;
            rd_q <= TDS_RST_BIT;
        end else begin
            rv_q <= rv_d;
            rd_q <= rd_d;
        end
    end

    tds_fifo #(.WIDTH(TDS_FIFO_WIDTH), .DEPTH(TDS_FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .rst_n(nrst),
        .in_valid(fin_valid),
        .in_ready(fin_ready),
        .in_data(dat_q),
        .out_valid(fout_valid),
        .out_ready(!rv_q || rec_ready),
        .out_data(fout_data)
    );

    assign tdo_o = tdo_q;
    assign tdo_oe = oe_q;
    assign upd_q_o = upd_q;
    assign tlr_o = tlr_q;
    assign rec_valid = rv_q;
    assign rec_data = rd_q;
endmodule
`default_nettype wire

// [src/tds_pkg.sv]
package tds_pkg;
    // Depth and width of the shifted-bit record buffer
    localparam int TDS_FIFO_DEPTH = 8;
    localparam int TDS_FIFO_WIDTH = 1;
    // Value taken by the bypass stage in Capture-DR
    localparam logic TDS_CAPTURE_VAL = 1'h0;
    // Reset values
    localparam logic TDS_RST_BIT = 1'h0;
    localparam logic [1:0] TDS_SYNC_RST = 2'h0;

    typedef enum logic [3:0] {
        TDS_TLR, TDS_RTI, TDS_SEL_DR, TDS_CAP_DR, TDS_SHIFT_DR, TDS_EXIT1_DR,
        TDS_PAUSE_DR, TDS_EXIT2_DR, TDS_UPD_DR, TDS_SEL_IR, TDS_CAP_IR,
        TDS_SHIFT_IR, TDS_EXIT1_IR, TDS_PAUSE_IR, TDS_EXIT2_IR, TDS_UPD_IR
    } tds_state_t;

    // IEEE 1149.1 next-state function
    function automatic tds_state_t tds_next(input tds_state_t s, input logic tms);
        tds_state_t n;
        n = s;
        unique case (s)
            TDS_TLR: n = tms ? TDS_TLR : TDS_RTI;
            TDS_RTI: n = tms ? TDS_SEL_DR : TDS_RTI;
            TDS_SEL_DR: n = tms ? TDS_SEL_IR : TDS_CAP_DR;
            TDS_CAP_DR: n = tms ? TDS_EXIT1_DR : TDS_SHIFT_DR;
            TDS_SHIFT_DR: n = tms ? TDS_EXIT1_DR : TDS_SHIFT_DR;
            TDS_EXIT1_DR: n = tms ? TDS_UPD_DR : TDS_PAUSE_DR;
            TDS_PAUSE_DR: n = tms ? TDS_EXIT2_DR : TDS_PAUSE_DR;
            TDS_EXIT2_DR: n = tms ? TDS_UPD_DR : TDS_SHIFT_DR;
            TDS_UPD_DR: n = tms ? TDS_SEL_DR : TDS_RTI;
            TDS_SEL_IR: n = tms ? TDS_TLR : TDS_CAP_IR;
            TDS_CAP_IR: n = tms ? TDS_EXIT1_IR : TDS_SHIFT_IR;
            TDS_SHIFT_IR: n = tms ? TDS_EXIT1_IR : TDS_SHIFT_IR;
            TDS_EXIT1_IR: n = tms ? TDS_UPD_IR : TDS_PAUSE_IR;
            TDS_PAUSE_IR: n = tms ? TDS_EXIT2_IR : TDS_PAUSE_IR;
            TDS_EXIT2_IR: n = tms ? TDS_UPD_IR : TDS_SHIFT_IR;
            TDS_UPD_IR: n = tms ? TDS_SEL_DR : TDS_RTI;
        endcase
        return n;
    endfunction
endpackage

// [src/tds_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module tds_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Async reset
    input wire logic in_valid, // Write request
    output logic in_ready, // Not full
    input wire logic [WIDTH-1:0] in_data, // Write data
    output logic out_valid, // Not empty
    input wire logic out_ready, // Read accept
    output logic [WIDTH-1:0] out_data // Head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic push, pop;

    assign in_ready = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
    assign out_valid = wp_q != rp_q;
    assign out_data = mem_q[rp_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wp_d = wp_q + (AW+1)'(push);
        rp_d = rp_q + (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    // Storage has no reset; only the pointers define contents
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// [bench/tds_top_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module tds_checker (
    input wire logic ref_clk, // Clock
    input wire logic nrst, // Reset
    input wire logic tck, // Seen
    input wire logic tdo_o, // Seen
    input wire logic tdo_oe, // Seen
    input wire logic upd_q_o, // Seen
    input wire logic tlr_o, // Seen
    input wire logic rec_valid, // Seen
    input wire logic rec_ready, // Seen
    input wire logic rec_data // Seen
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence oe_on;
        $rose(tdo_oe);
    endsequence
    a_oe_fall_only: assert property ($changed(tdo_oe) |-> !tck) else $error("oe moved");
    a_tdo_fall_only: assert property ($changed(tdo_o) |-> !tck) else $error("tdo moved");
    a_upd_fall_only: assert property ($changed(upd_q_o) |-> !tck) else $error("upd moved");
    a_tlr_fall_only: assert property ($changed(tlr_o) |-> !tck) else $error("tlr moved");
    a_first_zero: assert property (oe_on |-> !tdo_o) else $error("first not zero");
    a_oe_on_holds: assert property (oe_on |-> tdo_oe [*8]) else $error("oe short");
    a_oe_off_holds: assert property ($fell(tdo_oe) |-> !tdo_oe [*8]) else $error("oe back");
    a_rec_holds: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
        else $error("rec lost");
    a_rec_in_shift: assert property ($rose(rec_valid) |-> tdo_oe) else $error("rec early");
endmodule
bind tds_top tds_checker u_tds_checker (.ref_clk(ref_clk), .nrst(nrst), .tck(tck), .tdo_o(tdo_o),
    .tdo_oe(tdo_oe), .upd_q_o(upd_q_o), .tlr_o(tlr_o), .rec_valid(rec_valid), .rec_ready(rec_ready),
    .rec_data(rec_data));
`default_nettype wire

// [bench/tds_ctl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module tds_ctl_model (
    output logic tck, // Test clock
    output logic tms, // Mode
    output logic tdi, // Data
    input wire logic tdo_o, // Data back
    input wire logic tdo_oe // Enable back
);
    initial {tck, tms, tdi} = 3'h2;
    // Clock stands still between calls; a released tdo reads inverted
    task automatic step(input logic m, input logic d, output logic oe, output logic q);
        tck <= 1'h0;
        tms <= m;
        tdi <= d;
        #62.5;
        oe = tdo_oe;
        q = tdo_oe ? tdo_o : ~tdo_o;
        tck <= 1'h1;
        #62.5;
    endtask
endmodule
`default_nettype wire

// [bench/tds_top_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module tds_top_bench;
    logic ref_clk, nrst, tck, tms, tdi, tdo_o, tdo_oe, upd_q_o, tlr_o, rec_valid, rec_ready, rec_data, stall;
    int bad_count, compares;
    logic exp_q[$];
    tds_top u_tds_top (.ref_clk(ref_clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
        .tdo_oe(tdo_oe), .upd_q_o(upd_q_o), .tlr_o(tlr_o), .rec_valid(rec_valid), .rec_ready(rec_ready),
        .rec_data(rec_data));
    tds_ctl_model u_tds_ctl_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic exp_tdo(input int i, input logic [15:0] b);
        return (i == 0) ? 1'h0 : b[i-1];
    endfunction
    task automatic check(input logic seen, input logic want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH %0t seen %b want %b", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (rec_valid === 1'h1 && rec_ready === 1'h1) begin
            // An unexpected bit must not pass against an empty queue
            check(rec_data, (exp_q.size() > 0) ? exp_q.pop_front() : ~rec_data);
        end
        rec_ready <= !stall && ($urandom_range(1) != 0);
    end
    task automatic scan(input int n, input logic [15:0] b);
        logic oe, q;
        for (int i = 0; i < 4; i++) u_tds_ctl_model.step(i == 1, 1'($urandom), oe, q);
        check(tlr_o, 1'h0);
        for (int i = 0; i < n; i++) begin
            // Queued first: the bit can reach the consumer before the step returns
            exp_q.push_back(b[i]);
            u_tds_ctl_model.step(i == n - 1, b[i], oe, q);
            check(oe, 1'h1);
            check(q, exp_tdo(i, b));
        end
        u_tds_ctl_model.step(1'h1, 1'h0, oe, q);
        check(oe, 1'h0);
        u_tds_ctl_model.step(1'h1, 1'h0, oe, q);
        check(upd_q_o, b[n-1]);
        repeat (3) u_tds_ctl_model.step(1'h1, 1'h0, oe, q);
        check(tlr_o, 1'h1);
        if (stall) check(rec_valid, 1'h1);
        stall = 1'h0;
        for (int w = 0; w < 500 && exp_q.size() > 0; w++) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
        check(exp_q.size() == 0, 1'h1);
        check(rec_valid, 1'h0);
        $display("scan %0d done", n);
    endtask
    initial begin
        nrst = 1'h0;
        rec_ready = 1'h0;
        stall = 1'h0;
        void'($urandom(76778));
        repeat (3) @(posedge ref_clk);
        nrst <= 1'h1;
        repeat (5) @(posedge ref_clk);
        check(tlr_o, 1'h1);
        scan(3, 16'h0005);
        scan(1, 16'h0001);
        // Consumer stalled so the buffer fills and two bits wait outside it: one in the output stage, one in the holding flop
        stall = 1'h1;
        scan(10, 16'($urandom));
        repeat (4) scan(1 + $urandom_range(7), 16'($urandom));
        wrap_up();
    end
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
